// ---- rtl/pohp_pkg.sv ----
// constants shared by the output-disable, holdover-release and fine-phase register bank
// assumes a byte-wide register port with read data one cycle after the read strobe
package pohp_pkg;
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 8;
	localparam logic [7:0] OFS_DISABLE = 8'h14;
	localparam logic [7:0] OFS_CORE_CTRL = 8'h19;
	localparam logic [7:0] OFS_FINE_PHASE = 8'h1A;
	localparam logic [7:0] OFS_PRI_STATUS = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h31;
	localparam logic [7:0] RST_DISABLE = 8'h00;
	localparam logic [7:0] RST_CORE_CTRL = 8'h00;
	localparam logic [7:0] RST_FINE_PHASE = 8'h00;
	localparam logic [7:0] MASK_DISABLE = 8'h1F;
	localparam logic [7:0] MASK_CORE_CTRL = 8'h06;
	localparam int unsigned BIT_FRAME_HI122_OFF = 4;
	localparam int unsigned BIT_FRAME_LO244_OFF = 3;
	localparam int unsigned BIT_FRAME_LO61_OFF = 2;
	localparam int unsigned BIT_CLK_6M312_OFF = 1;
	localparam int unsigned BIT_CLK_19M44_OFF = 0;
	localparam int unsigned BIT_MANUAL_RELEASE = 2;
	localparam int unsigned BIT_AUTO_INHIBIT = 1;
	localparam int unsigned BIT_FREQ_LO = 3;
	localparam int unsigned BIT_ACQ_HOLDOVER = 1;
	localparam int unsigned BIT_LEGACY_LOCK = 0;
	// interrupt status bits: holdover entry, holdover exit, manual release
	localparam int unsigned IRQ_HOLD_ENTER = 0;
	localparam int unsigned IRQ_HOLD_EXIT = 1;
	localparam int unsigned IRQ_RELEASE = 2;
	localparam int unsigned IRQ_COUNT = 3;
	localparam int unsigned STEP_PS = 477;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// phase slews by at most one step per slew interval
	localparam int unsigned SLEW_INTERVAL_NS = 1000;
	localparam int unsigned SLEW_CYCLES = (SLEW_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		FREQ_19M44 = 2'h0,
		FREQ_8K = 2'h1,
		FREQ_1M544 = 2'h2,
		FREQ_2M048 = 2'h3
	} pohp_freq_type;
	typedef enum logic [1:0] {
		CORE_NORMAL = 2'h0,
		CORE_AUTO_HOLD = 2'h1,
		CORE_RELEASED = 2'h3
	} pohp_core_type;
endpackage

// ---- rtl/pohp_regs.sv ----
// register bank for output disables, holdover release control, fine phase shift and primary status
// assumes reg_*_in strobes are one cycle, synchronous to clk_in, never both high together
`timescale 1ns/1ps
module pohp_regs
	import pohp_pkg::*;
#(
	parameter int unsigned SLEW_CYCLES_P = SLEW_CYCLES
)
(
	input  wire logic                         clk_in,
	input  wire logic                         reset_in,
	input  wire logic [pohp_pkg::ADDR_WIDTH-1:0] reg_addr_in,
	input  wire logic [pohp_pkg::DATA_WIDTH-1:0] reg_wdata_in,
	input  wire logic                         reg_write_in,
	input  wire logic                         reg_read_in,
	output logic      [pohp_pkg::DATA_WIDTH-1:0] reg_rdata_out,
	input  wire logic [1:0]                   ref_freq_code_in,
	input  wire logic                         primary_acq_holdover_in,
	input  wire logic                         legacy_lock_flag_in,
	output logic                              frame_pulse_hi122_oe_out,
	output logic                              frame_pulse_lo244_oe_out,
	output logic                              frame_pulse_lo61_oe_out,
	output logic                              clk_out_6m312_oe_out,
	output logic                              clk_out_19m44_oe_out,
	output logic                              core_hold_out,
	output logic                              holdover_release_out,
	output logic      [pohp_pkg::DATA_WIDTH-1:0] fine_phase_target_out,
	output logic      [pohp_pkg::DATA_WIDTH-1:0] fine_phase_applied_out,
	output logic                              irq_out
);
	import pohp_pkg::*;

	// the slew counter is 16 bits wide, and a zero interval would wrap to one step every 65536 cycles
	if (SLEW_CYCLES_P < 1 || SLEW_CYCLES_P > 65535)
	begin
		$error("SLEW_CYCLES_P out of range");
	end

	typedef struct packed {
		logic [7:0]     disable_bits;
		logic [7:0]     core_ctrl;
		logic [7:0]     fine_phase;
		logic [7:0]     applied_phase;
		logic [15:0]    slew_cnt;
		pohp_core_type  core_state;
		logic           acq_hold_prev;
		logic           release_pulse;
		logic [IRQ_COUNT-1:0] irq_status;
		logic [IRQ_COUNT-1:0] irq_mask;
		logic [7:0]     rdata;
		logic           irq;
		logic [4:0]     out_en;
		logic           core_hold;
	} pohp_state_type;

	pohp_state_type state_q;
	pohp_state_type state_d;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	logic [7:0] status_word;
	logic       wr_disable;
	logic       wr_core;
	logic       wr_phase;
	logic       rise_release;
	logic       hold_enter;
	logic       hold_exit;
	logic [IRQ_COUNT-1:0] events;

	always_comb
	begin
		// reserved bits of the status read as zero
		status_word = 8'h00;
		status_word[BIT_FREQ_LO +: 2] = ref_freq_code_in;
		status_word[BIT_ACQ_HOLDOVER] = primary_acq_holdover_in;
		status_word[BIT_LEGACY_LOCK] = legacy_lock_flag_in;
		wr_disable = reg_write_in && hit(reg_addr_in, OFS_DISABLE);
		wr_core = reg_write_in && hit(reg_addr_in, OFS_CORE_CTRL);
		wr_phase = reg_write_in && hit(reg_addr_in, OFS_FINE_PHASE);
		// edge of the level-sensitive release bit; host clears it on the next write
		rise_release = wr_core && reg_wdata_in[BIT_MANUAL_RELEASE]
			&& !state_q.core_ctrl[BIT_MANUAL_RELEASE];
		hold_enter = primary_acq_holdover_in && !state_q.acq_hold_prev;
		hold_exit = !primary_acq_holdover_in && state_q.acq_hold_prev;
		events = '0;
		events[IRQ_HOLD_ENTER] = hold_enter;
		events[IRQ_HOLD_EXIT] = hold_exit;

		state_d = state_q;
		state_d.acq_hold_prev = primary_acq_holdover_in;
		state_d.release_pulse = 1'b0;
		if (wr_disable)
			state_d.disable_bits = reg_wdata_in & MASK_DISABLE;
		if (wr_core)
			state_d.core_ctrl = reg_wdata_in & MASK_CORE_CTRL;
		if (wr_phase)
			state_d.fine_phase = reg_wdata_in;

		unique case (state_q.core_state)
			CORE_NORMAL:
			begin
				if (hold_enter)
					state_d.core_state = CORE_AUTO_HOLD;
			end
			CORE_AUTO_HOLD:
			begin
				// release bit only counts while the inhibit bit is set
				if (rise_release && state_q.core_ctrl[BIT_AUTO_INHIBIT])
				begin
					state_d.core_state = CORE_RELEASED;
					state_d.release_pulse = 1'b1;
					events[IRQ_RELEASE] = 1'b1;
				end
				else if (hold_exit && !state_q.core_ctrl[BIT_AUTO_INHIBIT])
					state_d.core_state = CORE_NORMAL;
			end
			CORE_RELEASED:
			begin
				if (hold_enter)
					state_d.core_state = CORE_AUTO_HOLD;
				else
					state_d.core_state = CORE_NORMAL;
			end
			default:
				state_d.core_state = CORE_NORMAL;
		endcase

		// slew the applied offset one step at a time toward the target
		if (state_q.applied_phase == state_q.fine_phase)
			state_d.slew_cnt = '0;
		else if (state_q.slew_cnt >= 16'(SLEW_CYCLES_P - 1))
		begin
			state_d.slew_cnt = '0;
			if ($signed(state_q.fine_phase) > $signed(state_q.applied_phase))
				state_d.applied_phase = state_q.applied_phase + 8'h01;
			else
				state_d.applied_phase = state_q.applied_phase - 8'h01;
		end
		else
			state_d.slew_cnt = state_q.slew_cnt + 16'h0001;

		if (reg_write_in && hit(reg_addr_in, OFS_IRQ_MASK))
			state_d.irq_mask = reg_wdata_in[IRQ_COUNT-1:0];
		// set wins over write-one-to-clear
		if (reg_write_in && hit(reg_addr_in, OFS_IRQ_STATUS))
			state_d.irq_status = state_q.irq_status & ~reg_wdata_in[IRQ_COUNT-1:0];
		state_d.irq_status = state_d.irq_status | events;
		state_d.irq = |(state_d.irq_status & state_d.irq_mask);
		// enables and hold flag are registered so the pins never see decode glitches
		state_d.out_en = ~state_d.disable_bits[4:0];
		state_d.core_hold = (state_d.core_state == CORE_AUTO_HOLD);

		// writes to the status address fall through untouched
		state_d.rdata = 8'h00;
		if (reg_read_in)
		begin
			unique case (reg_addr_in)
				OFS_DISABLE:    state_d.rdata = state_q.disable_bits;
				OFS_CORE_CTRL:  state_d.rdata = state_q.core_ctrl;
				OFS_FINE_PHASE: state_d.rdata = state_q.fine_phase;
				OFS_PRI_STATUS: state_d.rdata = status_word;
				OFS_IRQ_STATUS: state_d.rdata = {{(8-IRQ_COUNT){1'b0}}, state_q.irq_status};
				OFS_IRQ_MASK:   state_d.rdata = {{(8-IRQ_COUNT){1'b0}}, state_q.irq_mask};
				default:        state_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			state_q.disable_bits <= RST_DISABLE;
			state_q.core_ctrl <= RST_CORE_CTRL;
			state_q.fine_phase <= RST_FINE_PHASE;
			state_q.applied_phase <= RST_FINE_PHASE;
			state_q.slew_cnt <= 16'h0000;
			state_q.core_state <= CORE_NORMAL;
			state_q.acq_hold_prev <= 1'b0;
			state_q.release_pulse <= 1'b0;
			state_q.irq_status <= '0;
			state_q.irq_mask <= '0;
			state_q.rdata <= 8'h00;
			state_q.irq <= 1'b0;
			state_q.out_en <= ~RST_DISABLE[4:0];
			state_q.core_hold <= 1'b0;
		end
		else
			state_q <= state_d;
	end

	// enables are the inverse of the disable bits
	assign frame_pulse_hi122_oe_out = state_q.out_en[BIT_FRAME_HI122_OFF];
	assign frame_pulse_lo244_oe_out = state_q.out_en[BIT_FRAME_LO244_OFF];
	assign frame_pulse_lo61_oe_out = state_q.out_en[BIT_FRAME_LO61_OFF];
	assign clk_out_6m312_oe_out = state_q.out_en[BIT_CLK_6M312_OFF];
	assign clk_out_19m44_oe_out = state_q.out_en[BIT_CLK_19M44_OFF];
	assign core_hold_out = state_q.core_hold;
	assign holdover_release_out = state_q.release_pulse;
	assign fine_phase_target_out = state_q.fine_phase;
	assign fine_phase_applied_out = state_q.applied_phase;
	assign reg_rdata_out = state_q.rdata;
	assign irq_out = state_q.irq;
endmodule

// ---- tb/pohp_regs_monitor.sv ----
// concurrent checks on the register bank ports
// bound into every pohp_regs instance
`timescale 1ns/1ps
module pohp_regs_monitor
(
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_write_in,
	input wire logic       reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [1:0] ref_freq_code_in,
	input wire logic       primary_acq_holdover_in,
	input wire logic       legacy_lock_flag_in,
	input wire logic       frame_pulse_hi122_oe_out,
	input wire logic       clk_out_19m44_oe_out,
	input wire logic       core_hold_out,
	input wire logic       holdover_release_out,
	input wire logic [7:0] fine_phase_target_out,
	input wire logic [7:0] fine_phase_applied_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	sequence s_wr(a);
		reg_write_in && reg_addr_in == a;
	endsequence
	sequence s_rd(a);
		reg_read_in && reg_addr_in == a;
	endsequence
	a_oe_hi122: assert property (s_wr(8'h14) |=> frame_pulse_hi122_oe_out == !$past(reg_wdata_in[4]))
		else $error("hi122 enable wrong");
	a_oe_19m44: assert property (s_wr(8'h14) |=> clk_out_19m44_oe_out == !$past(reg_wdata_in[0]))
		else $error("19m44 enable wrong");
	a_fine_wr: assert property (s_wr(8'h1A) |=> fine_phase_target_out == $past(reg_wdata_in))
		else $error("fine target wrong");
	a_status_rd: assert property (s_rd(8'h20) |=> reg_rdata_out == {3'h0, $past(ref_freq_code_in), 1'h0,
		$past(primary_acq_holdover_in), $past(legacy_lock_flag_in)}) else $error("status read wrong");
	a_rd_idle: assert property (!reg_read_in |=> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	a_rel_cause: assert property (holdover_release_out |-> $past(reg_write_in && reg_addr_in == 8'h19 && reg_wdata_in[2]))
		else $error("release without write");
	a_rel_pulse: assert property (holdover_release_out |-> !core_hold_out ##1 !holdover_release_out)
		else $error("release pulse wrong");
	// the filter may only creep one step per cycle at the fastest setting
	a_slew_step: assert property (fine_phase_applied_out - $past(fine_phase_applied_out) inside {8'h00, 8'h01, 8'hFF})
		else $error("phase jumped");
endmodule
bind pohp_regs pohp_regs_monitor u_mon (.clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
	.reg_read_in, .reg_rdata_out, .ref_freq_code_in, .primary_acq_holdover_in, .legacy_lock_flag_in,
	.frame_pulse_hi122_oe_out, .clk_out_19m44_oe_out, .core_hold_out, .holdover_release_out,
	.fine_phase_target_out, .fine_phase_applied_out);

// ---- tb/pohp_regs_tb_top.sv ----
// self-checking bench for the register bank
// drives the register port and status inputs itself; slew shortened to one cycle
`timescale 1ns/1ps
module pohp_regs_tb_top;
	import pohp_pkg::*;
	logic       clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [1:0] freq = 2'h0;
	logic       acq_hold = 1'b0;
	logic       lock = 1'b0;
	logic [7:0] rdata;
	logic [4:0] oe;
	logic       core_hold;
	logic       release_p;
	logic [7:0] target;
	logic [7:0] applied;
	logic       irq;
	int         n_fail = 0;
	int         tests_run = 0;
	int         n_rel = 0;
	always #25 clk_in = ~clk_in;
	// count pulses so a release is seen whatever cycle it lands in
	always @(posedge clk_in) if (release_p === 1'b1) n_rel <= n_rel + 1;
	pohp_regs #(.SLEW_CYCLES_P(1)) dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_rdata_out(rdata),
		.ref_freq_code_in(freq), .primary_acq_holdover_in(acq_hold), .legacy_lock_flag_in(lock),
		.frame_pulse_hi122_oe_out(oe[4]), .frame_pulse_lo244_oe_out(oe[3]), .frame_pulse_lo61_oe_out(oe[2]),
		.clk_out_6m312_oe_out(oe[1]), .clk_out_19m44_oe_out(oe[0]), .core_hold_out(core_hold),
		.holdover_release_out(release_p), .fine_phase_target_out(target), .fine_phase_applied_out(applied),
		.irq_out(irq));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk_in);
		wr_en <= 1'b0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_in);
		rd_en <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic t_disable;
		chk({3'h0, oe}, 8'h1F);
		rdc(8'h14, 8'h00);
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h14, 8'h01 << i);
			chk({3'h0, oe}, 8'h1F ^ (8'h01 << i));
		end
		wr(8'h14, 8'hFF);
		rdc(8'h14, 8'h1F);
		wr(8'h14, 8'h00);
		$display("disable test done");
	endtask
	task automatic t_phase;
		rdc(8'h1A, 8'h00);
		wr(8'h1A, 8'h80);
		rdc(8'h1A, 8'h80);
		chk(target, 8'h80);
		cyc(140);
		chk(applied, 8'h80);
		wr(8'h1A, 8'hFF);
		cyc(140);
		chk(applied, 8'hFF);
		$display("phase test done");
	endtask
	task automatic t_status;
		for (int f = 0; f < 4; f++)
		begin
			@(posedge clk_in);
			freq <= f[1:0];
			acq_hold <= f[0];
			lock <= f[1];
			rdc(8'h20, {3'h0, f[1:0], 1'b0, f[0], f[1]});
		end
		wr(8'h20, 8'hFF);
		rdc(8'h20, 8'h1B);
		rdc(8'h55, 8'h00);
		@(posedge clk_in);
		acq_hold <= 1'b0;
		cyc(3);
		$display("status test done");
	endtask
	task automatic t_hold;
		wr(8'h30, 8'h07);
		wr(8'h31, 8'h07);
		@(posedge clk_in);
		acq_hold <= 1'b1;
		cyc(3);
		chk(core_hold, 1'b1);
		wr(8'h19, 8'h04);
		cyc(2);
		chk(n_rel[7:0], 8'h00);
		@(posedge clk_in);
		acq_hold <= 1'b0;
		cyc(3);
		chk(core_hold, 1'b0);
		wr(8'h19, 8'h00);
		wr(8'h19, 8'h02);
		@(posedge clk_in);
		freq <= FREQ_8K;
		acq_hold <= 1'b1;
		cyc(3);
		@(posedge clk_in);
		acq_hold <= 1'b0;
		cyc(3);
		chk(core_hold, 1'b1);
		wr(8'h19, 8'h06);
		cyc(2);
		chk(n_rel[7:0], 8'h01);
		chk(core_hold, 1'b0);
		wr(8'h19, 8'h02);
		rdc(8'h19, 8'h02);
		rdc(8'h30, 8'h07);
		chk(irq, 1'b1);
		wr(8'h31, 8'h00);
		cyc(2);
		chk(irq, 1'b0);
		wr(8'h31, 8'h04);
		wr(8'h30, 8'h07);
		cyc(2);
		chk(irq, 1'b0);
		rdc(8'h30, 8'h00);
		$display("holdover test done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		t_disable();
		t_phase();
		t_status();
		t_hold();
		stop_test();
	end
	// whole run is near 400 cycles, so 4000 means a hang
	initial
	begin
		#200000;
		n_fail++;
		stop_test();
	end
endmodule
